//--- hdl/urxw_pkg.sv
// Package for the receive wake and multidrop support block
package urxw_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_RX_LOW    = 3'h0;
  localparam logic [2:0] ADDR_RX_HIGH   = 3'h1;
  localparam logic [2:0] ADDR_STATUS    = 3'h2;
  localparam logic [2:0] ADDR_IRQ_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_MODE_CTRL = 3'h4;

  // Status register bit positions
  localparam int BIT_RX_DONE    = 7;
  localparam int BIT_TX_DONE    = 6;
  localparam int BIT_TX_EMPTY   = 5;
  localparam int BIT_RX_START   = 4;
  localparam int BIT_SYNC_ERR   = 3;
  // Interrupt enable register bit positions
  localparam int BIT_RX_DONE_IE = 7;
  localparam int BIT_TX_DONE_IE = 6;
  localparam int BIT_TX_EMPT_IE = 5;
  localparam int BIT_RX_STRT_IE = 4;
  localparam int BIT_ABE_IE     = 2;
  // Mode register bit positions
  localparam int BIT_SFD_EN     = 4;
  localparam int BIT_IR_EVENT   = 1;
  localparam int BIT_MULTIDROP  = 0;
  // High receive byte bit positions
  localparam int BIT_OVERFLOW   = 6;

  // Reset values
  localparam logic [7:0] RST_IRQ_CTRL  = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [8:0] RST_RX_DATA   = 9'h000;

  // Wake state machine, one-hot
  typedef enum logic [1:0] {
    URXW_IDLE = 2'b01,
    URXW_RECV = 2'b10
  } urxw_wake_t;

  // One received frame as delivered by the framing datapath
  typedef struct packed {
    logic [8:0] data;
    logic       stop1;
    logic       nine;
  } urxw_frame_t;

  // Three interrupt vectors
  typedef struct packed {
    logic rx;
    logic tx_empty;
    logic tx_done;
  } urxw_vec_t;

endpackage

//--- hdl/urxw_core.sv
// Receive wake, multidrop filter, events and interrupt vector logic
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps

module urxw_core
  import urxw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        rx_pin,
  input  wire logic        standby,
  input  wire logic        async_mode,
  input  wire logic        rx_busy,
  input  wire logic        frame_valid,
  input  wire urxw_frame_t frame_in,
  input  wire logic        false_start,
  input  wire logic        sync_error,
  input  wire logic        tx_buf_empty,
  input  wire logic        tx_shift_done,
  input  wire logic        host_clock_mode,
  input  wire logic        transfer_clock,
  input  wire logic        infrared_event_input,
  output logic             osc_request,
  output logic             peripheral_clock_request,
  output logic             sys_wake_request,
  output logic             osc_keep,
  output logic             sleep_allow,
  output logic             transfer_clock_out,
  output logic             infrared_pulse,
  output urxw_vec_t        vectors
);

  // Whole module state
  typedef struct packed {
    logic [2:0]  rx_sync;
    logic [2:0]  ir_sync;
    urxw_wake_t  wake;
    logic [8:0]  rx_data;
    logic        rx_full;
    logic        overflow;
    logic        rx_start_flag;
    logic        sync_flag;
    logic        tx_done_flag;
    logic        xck_event;
    logic        ir_pulse;
    logic [7:0]  irq_ctrl;
    logic [7:0]  mode_ctrl;
    logic [7:0]  rdata;
  } urxw_state_t;

  // Reset image of the whole state; the line chain starts at idle high
  localparam urxw_state_t ST_RESET = '{
    rx_sync:       3'h7,
    ir_sync:       3'h0,
    wake:          URXW_IDLE,
    rx_data:       RST_RX_DATA,
    rx_full:       1'b0,
    overflow:      1'b0,
    rx_start_flag: 1'b0,
    sync_flag:     1'b0,
    tx_done_flag:  1'b0,
    xck_event:     1'b0,
    ir_pulse:      1'b0,
    irq_ctrl:      RST_IRQ_CTRL,
    mode_ctrl:     RST_MODE_CTRL,
    rdata:         8'h00
  };

  urxw_state_t st;
  urxw_state_t next_st;

  logic rx_fall;
  logic type_bit;
  logic accept;
  logic pop;
  logic w1c_status;
  logic sfd_on;

  // Edge on the twice-synchronised line; stage 0 feeds only stage 1
  assign rx_fall = st.rx_sync[2] & ~st.rx_sync[1];
  // Start-of-frame wake needs its enable and asynchronous framing
  assign sfd_on = st.mode_ctrl[BIT_SFD_EN] & async_mode;
  // Frame type bit depends on character size
  assign type_bit = frame_in.nine ? frame_in.data[8] : frame_in.stop1;
  // Filter drops data frames while multidrop mode is on
  assign accept = frame_valid &
                  (~st.mode_ctrl[BIT_MULTIDROP] | type_bit);
  assign pop = reg_read & (reg_addr == ADDR_RX_LOW);
  assign w1c_status = reg_write & (reg_addr == ADDR_STATUS);

  // Next state
  always_comb begin
    next_st = st;
    next_st.rx_sync = {st.rx_sync[1:0], rx_pin};
    next_st.ir_sync = {st.ir_sync[1:0], infrared_event_input};
    // Rising edge of the synced infrared input gives a one-cycle pulse
    next_st.ir_pulse = st.mode_ctrl[BIT_IR_EVENT] &
                       st.ir_sync[1] & ~st.ir_sync[2];
    // Clock event follows the transfer clock level, one pulse per period
    next_st.xck_event = host_clock_mode & transfer_clock;

    // Wake machine holds its request from edge to frame end
    case (st.wake)
      URXW_IDLE: begin
        if (standby & sfd_on & rx_fall) begin
          next_st.wake = URXW_RECV;
        end
      end
      URXW_RECV: begin
        if (frame_valid | false_start) begin
          next_st.wake = URXW_IDLE;
        end
      end
      default: next_st.wake = URXW_IDLE;
    endcase

    // Receive holding register; done flag is its occupancy
    if (pop) begin
      next_st.rx_full = 1'b0;
      next_st.overflow = 1'b0;
    end
    if (accept) begin
      if (st.rx_full & ~pop) begin
        next_st.overflow = 1'b1;
      end else begin
        next_st.rx_data = frame_in.data;
        next_st.rx_full = 1'b1;
      end
    end

    // Write-one-to-clear flags; a same-cycle set beats the clear
    if (w1c_status & reg_wdata[BIT_RX_START]) begin
      next_st.rx_start_flag = 1'b0;
    end
    if (w1c_status & reg_wdata[BIT_SYNC_ERR]) begin
      next_st.sync_flag = 1'b0;
    end
    if (w1c_status & reg_wdata[BIT_TX_DONE]) begin
      next_st.tx_done_flag = 1'b0;
    end
    if (st.wake == URXW_IDLE && standby && sfd_on && rx_fall) begin
      next_st.rx_start_flag = 1'b1;
    end
    if (sync_error) begin
      next_st.sync_flag = 1'b1;
    end
    if (tx_shift_done & tx_buf_empty) begin
      next_st.tx_done_flag = 1'b1;
    end

    // Control register writes
    if (reg_write && reg_addr == ADDR_IRQ_CTRL) begin
      next_st.irq_ctrl = reg_wdata;
    end
    if (reg_write && reg_addr == ADDR_MODE_CTRL) begin
      next_st.mode_ctrl = reg_wdata;
    end

    // Read data stands in the cycle after the strobe only
    next_st.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        ADDR_RX_LOW:    next_st.rdata = st.rx_data[7:0];
        ADDR_RX_HIGH:   next_st.rdata = {st.rx_full, st.overflow,
                                         5'h00, st.rx_data[8]};
        ADDR_STATUS:    next_st.rdata = {st.rx_full, st.tx_done_flag,
                                         tx_buf_empty, st.rx_start_flag,
                                         st.sync_flag, 3'h0};
        ADDR_IRQ_CTRL:  next_st.rdata = st.irq_ctrl;
        ADDR_MODE_CTRL: next_st.rdata = st.mode_ctrl;
        default:        next_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset loads a constant image only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Clock controller handshakes
  // Oscillator and port clock only while a woken frame is received
  assign osc_request = (st.wake == URXW_RECV);
  assign peripheral_clock_request = (st.wake == URXW_RECV);
  // System wake depends on which receive interrupt is enabled;
  // with both off only the oscillator and port clock run and frames may be lost
  assign sys_wake_request = standby & sfd_on &
    ((st.irq_ctrl[BIT_RX_STRT_IE] & st.rx_start_flag) |
     (~st.irq_ctrl[BIT_RX_STRT_IE] & st.irq_ctrl[BIT_RX_DONE_IE] &
      st.rx_full));
  // Sleep may not stop the oscillator mid-transfer
  assign osc_keep = (st.wake == URXW_RECV) | rx_busy;
  assign sleep_allow = (st.wake == URXW_IDLE) & ~rx_busy;

  // Interrupt vectors: flag and enable both set
  assign vectors.rx = (st.rx_full & st.irq_ctrl[BIT_RX_DONE_IE]) |
                      (st.rx_start_flag & st.irq_ctrl[BIT_RX_STRT_IE]) |
                      (st.sync_flag & st.irq_ctrl[BIT_ABE_IE]);
  assign vectors.tx_empty = tx_buf_empty &
                            st.irq_ctrl[BIT_TX_EMPT_IE];
  assign vectors.tx_done = st.tx_done_flag &
                           st.irq_ctrl[BIT_TX_DONE_IE];

  assign reg_rdata = st.rdata;
  assign transfer_clock_out = st.xck_event;
  assign infrared_pulse = st.ir_pulse;

  // Checks
  property p_wake_enter;
    @(posedge clk_sys) disable iff (reset)
    (st.wake == URXW_IDLE && standby && sfd_on && rx_fall)
      |=> osc_request && peripheral_clock_request && st.rx_start_flag;
  endproperty
  a_wake_enter: assert property (p_wake_enter)
    else $error("wake edge did not raise clock requests");

  property p_false_start;
    @(posedge clk_sys) disable iff (reset)
    (osc_request && false_start) |=> !osc_request;
  endproperty
  a_false_start: assert property (p_false_start)
    else $error("false start did not drop wake request");

  property p_sfd_off;
    @(posedge clk_sys) disable iff (reset)
    (!sfd_on && st.wake == URXW_IDLE) |=> !osc_request;
  endproperty
  a_sfd_off: assert property (p_sfd_off)
    else $error("wake without enable or outside async mode");

  property p_hold;
    @(posedge clk_sys) disable iff (reset)
    (osc_request && !frame_valid && !false_start) |=> osc_request;
  endproperty
  a_hold: assert property (p_hold)
    else $error("wake request dropped mid frame");

  property p_start_wake;
    @(posedge clk_sys) disable iff (reset)
    (standby && sfd_on && st.irq_ctrl[BIT_RX_STRT_IE] && rx_fall &&
     st.wake == URXW_IDLE) |=> sys_wake_request;
  endproperty
  a_start_wake: assert property (p_start_wake)
    else $error("start interrupt did not wake system");

  property p_osc_only;
    @(posedge clk_sys) disable iff (reset)
    (!st.irq_ctrl[BIT_RX_STRT_IE] && !st.irq_ctrl[BIT_RX_DONE_IE])
      |-> !sys_wake_request;
  endproperty
  a_osc_only: assert property (p_osc_only)
    else $error("system woken with both receive interrupts off");

  property p_drop_data;
    @(posedge clk_sys) disable iff (reset)
    (frame_valid && st.mode_ctrl[BIT_MULTIDROP] && !type_bit &&
     !st.rx_full) |=> !st.rx_full;
  endproperty
  a_drop_data: assert property (p_drop_data)
    else $error("data frame accepted in multidrop mode");

  property p_take_addr;
    @(posedge clk_sys) disable iff (reset)
    (frame_valid && type_bit && !st.rx_full)
      |=> st.rx_full && st.rx_data == $past(frame_in.data);
  endproperty
  a_take_addr: assert property (p_take_addr)
    else $error("address frame not taken");

  property p_pop;
    @(posedge clk_sys) disable iff (reset)
    (pop && !accept) |=> !st.rx_full &&
      (!vectors.rx || st.rx_start_flag || st.sync_flag);
  endproperty
  a_pop: assert property (p_pop)
    else $error("done flag survived buffer read");

  property p_rx_vec;
    @(posedge clk_sys) disable iff (reset)
    (st.sync_flag && st.irq_ctrl[BIT_ABE_IE]) |-> vectors.rx;
  endproperty
  a_rx_vec: assert property (p_rx_vec)
    else $error("sync error did not request receive vector");

  property p_tx_done;
    @(posedge clk_sys) disable iff (reset)
    (tx_shift_done && tx_buf_empty && st.irq_ctrl[BIT_TX_DONE_IE])
      |=> vectors.tx_done;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("transmit complete not requested");

  property p_ir;
    @(posedge clk_sys) disable iff (reset)
    infrared_pulse |=> !infrared_pulse;
  endproperty
  a_ir: assert property (p_ir)
    else $error("infrared pulse longer than one cycle");

  property p_done_wake;
    @(posedge clk_sys) disable iff (reset)
    (standby && sfd_on && !st.irq_ctrl[BIT_RX_STRT_IE] &&
     st.irq_ctrl[BIT_RX_DONE_IE]) |-> sys_wake_request == st.rx_full;
  endproperty
  a_done_wake: assert property (p_done_wake)
    else $error("system wake did not follow receive complete");

  property p_keep;
    @(posedge clk_sys) disable iff (reset)
    rx_busy |-> osc_keep && !sleep_allow;
  endproperty
  a_keep: assert property (p_keep)
    else $error("oscillator released during a transfer");

  property p_xck;
    @(posedge clk_sys) disable iff (reset)
    (host_clock_mode && transfer_clock) |=> transfer_clock_out;
  endproperty
  a_xck: assert property (p_xck)
    else $error("transfer clock event missing");

  property p_flag_set;
    @(posedge clk_sys) disable iff (reset)
    sync_error |=> st.sync_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("sync error flag lost to a same cycle clear");

  property p_ovf;
    @(posedge clk_sys) disable iff (reset)
    (accept && st.rx_full && !pop)
      |=> st.overflow && st.rx_full && st.rx_data == $past(st.rx_data);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("full buffer overwritten by a new frame");

  c_wake_frame: cover property (@(posedge clk_sys) disable iff (reset)
    osc_request ##[1:200] frame_valid);
  c_false: cover property (@(posedge clk_sys) disable iff (reset)
    osc_request && false_start);
  c_drop: cover property (@(posedge clk_sys) disable iff (reset)
    frame_valid && !accept);
  c_ovf: cover property (@(posedge clk_sys) disable iff (reset)
    accept && st.rx_full);
  c_addr: cover property (@(posedge clk_sys) disable iff (reset)
    frame_valid && st.mode_ctrl[BIT_MULTIDROP] && type_bit);

endmodule

//--- tb/urxw_peer.sv
// Far serial node model driving the receive framing signals
`timescale 1ns/100ps
module urxw_peer
  import urxw_pkg::*;
(
  input  wire logic   clk_sys,
  output logic        rx_pin,
  output logic        rx_busy,
  output logic        frame_valid,
  output urxw_frame_t frame_in,
  output logic        false_start
);
  // Line idles high; released frame bits never hold their last value
  initial begin
    rx_pin      = 1'b1;
    rx_busy     = 1'b0;
    frame_valid = 1'b0;
    false_start = 1'b0;
    frame_in    = 11'h000;
  end

  // Start edge, busy span, then one result pulse
  task automatic send(input logic [8:0] d, input logic s1,
                      input logic n9, input logic bad);
    @(posedge clk_sys);
    rx_pin  <= 1'b0;
    rx_busy <= 1'b1;
    repeat (8) @(posedge clk_sys);
    frame_valid <= !bad;
    false_start <= bad;
    frame_in    <= {d, s1, n9};
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    false_start <= 1'b0;
    frame_in    <= ~{d, s1, n9};
    rx_pin      <= 1'b1;
    rx_busy     <= 1'b0;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the receive wake and multidrop block
`timescale 1ns/100ps
module tb;
  import urxw_pkg::*;
  logic clk_sys, reset, reg_write, reg_read, rx_pin, standby, async_mode;
  logic rx_busy, frame_valid, false_start, sync_error, tx_buf_empty;
  logic tx_shift_done, host_clock_mode, transfer_clock;
  logic infrared_event_input, osc_request, peripheral_clock_request;
  logic sys_wake_request, osc_keep, sleep_allow, transfer_clock_out;
  logic infrared_pulse;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  urxw_frame_t frame_in;
  urxw_vec_t   vectors;
  int          failures, checked, i, n;
  logic [7:0]  ie_t [3] = '{8'h00, 8'h80, 8'h10};
  logic        mid_t [3] = '{1'b0, 1'b0, 1'b1};
  logic        post_t [3] = '{1'b0, 1'b1, 1'b1};
  logic [7:0]  md_t [3] = '{8'h00, 8'h10, 8'h10};
  logic        as_t [3] = '{1'b1, 1'b0, 1'b1};
  logic        sb_t [3] = '{1'b1, 1'b1, 1'b0};

  urxw_core u_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .rx_pin, .standby, .async_mode, .rx_busy,
    .frame_valid, .frame_in, .false_start, .sync_error, .tx_buf_empty,
    .tx_shift_done, .host_clock_mode, .transfer_clock,
    .infrared_event_input, .osc_request, .peripheral_clock_request,
    .sys_wake_request, .osc_keep, .sleep_allow, .transfer_clock_out,
    .infrared_pulse, .vectors);
  urxw_peer u_peer (.clk_sys, .rx_pin, .rx_busy, .frame_valid,
    .frame_in, .false_start);

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic v, input logic e);
    checked++;
    if (v !== e) begin
      failures++;
      $display("CHECK FAILED %0t output level wrong", $time);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    checked++;
    if (reg_rdata !== e) begin
      failures++;
      $display("CHECK FAILED %0t read %h got %h", $time, a, reg_rdata);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // Watchdog far above the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end

  initial begin
    {reset, reg_write, reg_read, sync_error, tx_buf_empty} = 5'h10;
    {tx_shift_done, host_clock_mode, transfer_clock} = 3'h0;
    {reg_addr, reg_wdata, infrared_event_input} = 12'h000;
    {standby, async_mode} = 2'h3;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ADDR_IRQ_CTRL, RST_IRQ_CTRL);
    rd(ADDR_MODE_CTRL, RST_MODE_CTRL);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    // Wake behaviour with receive interrupts off, done only and start only
    wr(ADDR_MODE_CTRL, 8'h10);
    for (i = 0; i < 3; i++) begin
      wr(ADDR_IRQ_CTRL, ie_t[i]);
      fork
        u_peer.send(9'h0a5, 1'b1, 1'b0, 1'b0);
        begin
          tick(6);
          chk(osc_request, 1'b1);
          chk(peripheral_clock_request, 1'b1);
          chk(sys_wake_request, mid_t[i]);
        end
      join
      tick(2);
      chk(osc_request, 1'b0);
      chk(sys_wake_request, post_t[i]);
      chk(vectors.rx, post_t[i]);
      rd(ADDR_STATUS, 8'h90);
      wr(ADDR_STATUS, 8'h10);
      rd(ADDR_RX_HIGH, 8'h80);
      rd(ADDR_RX_LOW, 8'ha5);
      chk(vectors.rx, 1'b0);
    end
    // False start falls back to sleep
    wr(ADDR_IRQ_CTRL, 8'h00);
    u_peer.send(9'h000, 1'b1, 1'b0, 1'b1);
    tick(2);
    chk(osc_request, 1'b0);
    chk(sleep_allow, 1'b1);
    wr(ADDR_STATUS, 8'h10);
    // Wake off, sync mode or awake: standard receive only
    for (i = 0; i < 3; i++) begin
      wr(ADDR_MODE_CTRL, md_t[i]);
      async_mode <= as_t[i];
      standby    <= sb_t[i];
      fork
        u_peer.send(9'h03c, 1'b1, 1'b0, 1'b0);
        begin
          tick(6);
          chk(osc_request, 1'b0);
          chk(osc_keep, 1'b1);
          chk(sleep_allow, 1'b0);
        end
      join
      rd(ADDR_STATUS, 8'h80);
      rd(ADDR_RX_LOW, 8'h3c);
    end
    // Multidrop filter, controller toggles the mode
    wr(ADDR_MODE_CTRL, 8'h01);
    u_peer.send(9'h055, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h00);
    u_peer.send(9'h0aa, 1'b1, 1'b1, 1'b0);
    rd(ADDR_STATUS, 8'h00);
    u_peer.send(9'h1c3, 1'b0, 1'b1, 1'b0);
    rd(ADDR_RX_HIGH, 8'h81);
    rd(ADDR_RX_LOW, 8'hc3);
    u_peer.send(9'h033, 1'b1, 1'b0, 1'b0);
    rd(ADDR_RX_LOW, 8'h33);
    wr(ADDR_MODE_CTRL, 8'h00);
    u_peer.send(9'h044, 1'b0, 1'b0, 1'b0);
    u_peer.send(9'h077, 1'b0, 1'b0, 1'b0);
    rd(ADDR_RX_HIGH, 8'hc0);
    rd(ADDR_RX_LOW, 8'h44);
    rd(ADDR_RX_HIGH, 8'h00);
    wr(ADDR_MODE_CTRL, 8'h01);
    u_peer.send(9'h066, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'h00);
    // Transmit vectors and sync error source
    wr(ADDR_IRQ_CTRL, 8'h64);
    tx_buf_empty <= 1'b1;
    tick(1);
    chk(vectors.tx_empty, 1'b1);
    @(posedge clk_sys);
    tx_shift_done <= 1'b1;
    sync_error    <= 1'b1;
    @(posedge clk_sys);
    tx_shift_done <= 1'b0;
    sync_error    <= 1'b0;
    tx_buf_empty  <= 1'b0;
    tick(2);
    chk(vectors.tx_empty, 1'b0);
    chk(vectors.tx_done, 1'b1);
    chk(vectors.rx, 1'b1);
    wr(ADDR_STATUS, 8'h48);
    tick(1);
    chk(vectors.tx_done, 1'b0);
    chk(vectors.rx, 1'b0);
    // Transfer clock event and infrared pulse event; events need enable
    wr(ADDR_MODE_CTRL, 8'h02);
    host_clock_mode <= 1'b1;
    transfer_clock  <= 1'b1;
    tick(2);
    chk(transfer_clock_out, 1'b1);
    @(posedge clk_sys);
    host_clock_mode <= 1'b0;
    infrared_event_input <= 1'b1;
    n = 0;
    for (i = 0; i < 8; i++) begin
      tick(1);
      if (infrared_pulse === 1'b1) n++;
    end
    chk(transfer_clock_out, 1'b0);
    chk(n == 1, 1'b1);
    print_verdict();
  end
endmodule
